/* rtl/pwm_pkg.sv */
// Shared constants for the timer based 10-bit pulse width modulator
package pwm_pkg;
  localparam int          NUM_CH        = 2;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  localparam int          PRE_W         = 6;
  // Register map
  localparam logic [3:0]  ADDR_PERIOD   = 4'h0;
  localparam logic [3:0]  ADDR_TIMER    = 4'h1;
  localparam logic [3:0]  ADDR_TIMEBASE = 4'h2;
  localparam logic [3:0]  ADDR_STATUS   = 4'h3;
  // Channel n sits at word group n+1, offsets below
  localparam logic [1:0]  CH_GROUP_OFS  = 2'h1;
  localparam logic [1:0]  OFS_DUTY_HIGH = 2'h0;
  localparam logic [1:0]  OFS_DUTY_LOW  = 2'h1;
  localparam logic [1:0]  OFS_CTRL      = 2'h2;
  // Field positions
  localparam int          TMR_ON_BIT    = 7;
  localparam int          POST_LSB      = 2;
  localparam int          POST_MSB      = 5;
  localparam int          PRESC_LSB     = 0;
  localparam int          PRESC_MSB     = 1;
  localparam int          DUTY_LOW_MSB  = 7;
  localparam int          DUTY_LOW_LSB  = 6;
  localparam int          CH_EN_BIT     = 7;
  localparam int          CH_OUT_BIT    = 5;
  localparam int          CH_INV_BIT    = 4;
  localparam int          POST_FLAG_BIT = 0;
  // Reset values
  localparam logic [7:0]  PERIOD_RST    = 8'hff;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [1:0]  PHASE_LAST    = 2'h3;

  typedef enum logic [1:0] {PRESC_1, PRESC_4, PRESC_16, PRESC_64}
    presc_type;

  // Last prescaler count before a timebase step
  function automatic logic [PRE_W-1:0] presc_max(input logic [1:0] sel);
    case (presc_type'(sel))
      PRESC_1:  presc_max = 6'h00;
      PRESC_4:  presc_max = 6'h03;
      PRESC_16: presc_max = 6'h0f;
      PRESC_64: presc_max = 6'h3f;
      default:  presc_max = 6'h00;
    endcase
  endfunction
endpackage

/* rtl/pwm_timebase.sv */
// Shared 10-bit timebase: prescaler, two phase bits and 8-bit counter
`timescale 1ns/1ns
module pwm_timebase
  import pwm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] presc_sel,
  input  wire logic [7:0] period,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  // Timebase
  output logic      [7:0] count,
  output logic      [1:0] phase,
  output logic            tick,
  output logic            period_start
);
  logic [PRE_W-1:0] pre_cnt;
  logic             wrap;

  assign tick = run && (pre_cnt >= presc_max(presc_sel));
  assign wrap = tick && (phase == PHASE_LAST);
  assign period_start = wrap && (count == period) && !load;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pre_cnt <= '0;
    else if (load || tick)
      pre_cnt <= '0;
    else if (run)
      pre_cnt <= pre_cnt + 6'h01;
  end

  // Low two bits count oscillator cycles after prescaling
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      phase <= '0;
    else if (load)
      phase <= '0;
    else if (tick)
      phase <= phase + 2'h1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (period_start)
      count <= '0;
    else if (wrap)
      count <= count + 8'h01;
  end

  sequence s_match_step;
    wrap && count == period && !load;
  endsequence

  property p_clear_on_match;
    @(posedge clk) disable iff (!nrst)
      s_match_step |=> count == '0 && phase == '0;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match)
    else $error("timebase not cleared after period match");

  property p_direct_clock;
    @(posedge clk) disable iff (!nrst)
      run && presc_sel == PRESC_1 && !load |=> phase == $past(phase) + 2'h1;
  endproperty
  a_direct_clock: assert property (p_direct_clock)
    else $error("timebase does not step every clock at 1:1");
endmodule

/* rtl/pwm_channel.sv */
// One modulator channel: duty buffer and active level
`timescale 1ns/1ns
module pwm_channel
  import pwm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Shared timebase
  input  wire logic       enable,
  input  wire logic       period_start,
  input  wire logic [9:0] timebase,
  input  wire logic [7:0] period,
  // Software duty value
  input  wire logic [7:0] duty_high,
  input  wire logic [1:0] duty_low_top,
  // State
  output logic            level,
  output logic      [9:0] duty_buf
);
  logic [9:0] new_duty;
  logic       active;

  assign new_duty = {duty_high, duty_low_top};
  // Output drops in the very cycle the timebase reaches the duty value
  assign level = active && (timebase != duty_buf);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      duty_buf <= '0;
    else if (period_start)
      duty_buf <= new_duty;
  end

  // Duty at or above the whole period never meets the timebase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      active <= 1'b0;
    else if (!enable)
      active <= 1'b0;
    else if (period_start)
      active <= (new_duty != '0);
    else if (timebase == duty_buf)
      active <= 1'b0;
  end

  property p_set_on_start;
    @(posedge clk) disable iff (!nrst)
      enable && period_start && new_duty != '0 |=> level;
  endproperty
  a_set_on_start: assert property (p_set_on_start)
    else $error("output not set at new period");

  property p_clear_on_duty;
    @(posedge clk) disable iff (!nrst)
      !period_start && timebase == duty_buf |=> !level;
  endproperty
  a_clear_on_duty: assert property (p_clear_on_duty)
    else $error("output not cleared at duty match");

  property p_full_duty;
    @(posedge clk) disable iff (!nrst)
      enable && level && !period_start &&
      {2'b00, duty_buf} >= ({2'b00, period} + 10'h001) * 10'h004
      |=> level;
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("full duty output was cleared");

  property p_buffer_hold;
    @(posedge clk) disable iff (!nrst)
      !period_start |=> duty_buf == $past(duty_buf);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold)
    else $error("duty buffer changed outside period match");

  property p_zero_duty;
    @(posedge clk) disable iff (!nrst)
      period_start && new_duty == '0 |=> !level;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("zero duty output went active");
endmodule

/* rtl/timer_based_pwm_10bit.sv */
// Top of the timer based 10-bit modulator with its register port
`timescale 1ns/1ns
// Contract
// - One shared period, per-channel duty
// - Output goes high when timebase clears, unless the new duty is zero
// - Output goes low at 10-bit duty match
// - Duty at or above period stays high
// - Duty registers buffered, loaded at period match
// - Invert bit flips channel output polarity
// - Period is (period+1) times 4 times prescale
// - After match: clear, set output, latch duty
// - Postscaler never affects modulator period
// - Duty is high byte plus bits 7:6
// - Pulse width is duty times prescaled clock
// - Ratio is duty over 4(period+1)
// - Timebase extends counter with two phase bits
module timer_based_pwm_10bit
  import pwm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Modulator pins and postscaled event
  output logic      [NUM_CH-1:0] pwm_pin,
  output logic                   postscale_tick
);
  logic [7:0]        period;
  logic              timer_on;
  logic [1:0]        presc_sel;
  logic [3:0]        post_sel;
  logic [3:0]        post_cnt;
  logic              post_flag;
  logic [7:0]        duty_high [NUM_CH];
  logic [1:0]        duty_low  [NUM_CH];
  logic [NUM_CH-1:0] ch_en;
  logic [NUM_CH-1:0] ch_inv;
  logic [NUM_CH-1:0] level;
  logic [9:0]        duty_buf  [NUM_CH];
  logic [7:0]        count;
  logic [1:0]        phase;
  logic              tick;
  logic              period_start;
  logic              tb_load;
  logic [7:0]        next_rdata;
  logic [1:0]        grp;
  logic [1:0]        ofs;
  logic              post_hit;

  assign grp = reg_addr[3:2];
  assign ofs = reg_addr[1:0];
  assign tb_load = reg_wr && reg_addr == ADDR_TIMEBASE;
  assign post_hit = period_start && post_cnt == post_sel;

  // Shared timebase
  pwm_timebase u_timebase (
    .clk          (clk),
    .nrst         (nrst),
    .run          (timer_on),
    .presc_sel    (presc_sel),
    .period       (period),
    .load         (tb_load),
    .load_value   (reg_wdata),
    .count        (count),
    .phase        (phase),
    .tick         (tick),
    .period_start (period_start)
  );

  // All channels see the same timebase and period
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    pwm_channel u_channel (
      .clk          (clk),
      .nrst         (nrst),
      .enable       (ch_en[i]),
      .period_start (period_start),
      .timebase     ({count, phase}),
      .period       (period),
      .duty_high    (duty_high[i]),
      .duty_low_top (duty_low[i]),
      .level        (level[i]),
      .duty_buf     (duty_buf[i])
    );
  end

  // Period register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      period <= PERIOD_RST;
    else if (reg_wr && reg_addr == ADDR_PERIOD)
      period <= reg_wdata;
  end

  // Timer control
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timer_on  <= 1'b0;
      presc_sel <= '0;
      post_sel  <= '0;
    end
    else if (reg_wr && reg_addr == ADDR_TIMER)
    begin
      timer_on  <= reg_wdata[TMR_ON_BIT];
      presc_sel <= reg_wdata[PRESC_MSB:PRESC_LSB];
      post_sel  <= reg_wdata[POST_MSB:POST_LSB];
    end
  end

  // Postscaler only counts periods; it feeds nothing back
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      post_cnt <= '0;
    else if (post_hit)
      post_cnt <= '0;
    else if (period_start)
      post_cnt <= post_cnt + 4'h1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      postscale_tick <= 1'b0;
    else
      postscale_tick <= post_hit;
  end

  // Sticky event flag, write one to clear, set wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      post_flag <= 1'b0;
    else if (post_hit)
      post_flag <= 1'b1;
    else if (reg_wr && reg_addr == ADDR_STATUS &&
             reg_wdata[POST_FLAG_BIT])
      post_flag <= 1'b0;
  end

  // Channel registers, writable at any time
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        duty_high[i] <= BYTE_ZERO;
        duty_low[i]  <= '0;
        ch_en[i]     <= 1'b0;
        ch_inv[i]    <= 1'b0;
      end
    end
    else if (reg_wr)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (grp == 2'(i) + CH_GROUP_OFS)
        begin
          if (ofs == OFS_DUTY_HIGH)
            duty_high[i] <= reg_wdata;
          if (ofs == OFS_DUTY_LOW)
            duty_low[i] <= reg_wdata[DUTY_LOW_MSB:DUTY_LOW_LSB];
          if (ofs == OFS_CTRL)
          begin
            ch_en[i]  <= reg_wdata[CH_EN_BIT];
            ch_inv[i] <= reg_wdata[CH_INV_BIT];
          end
        end
      end
    end
  end

  // Pin drivers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pwm_pin <= '0;
    else
      pwm_pin <= ch_en & (level ^ ch_inv);
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = BYTE_ZERO;
    case (reg_addr)
      ADDR_PERIOD:
        next_rdata = period;
      ADDR_TIMER:
      begin
        next_rdata[TMR_ON_BIT]          = timer_on;
        next_rdata[POST_MSB:POST_LSB]   = post_sel;
        next_rdata[PRESC_MSB:PRESC_LSB] = presc_sel;
      end
      ADDR_TIMEBASE:
        next_rdata = count;
      ADDR_STATUS:
        next_rdata[POST_FLAG_BIT] = post_flag;
      default:
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (grp == 2'(i) + CH_GROUP_OFS)
          begin
            if (ofs == OFS_DUTY_HIGH)
              next_rdata = duty_high[i];
            else if (ofs == OFS_DUTY_LOW)
              next_rdata[DUTY_LOW_MSB:DUTY_LOW_LSB] = duty_low[i];
            else if (ofs == OFS_CTRL)
            begin
              next_rdata[CH_EN_BIT]  = ch_en[i];
              next_rdata[CH_OUT_BIT] = pwm_pin[i];
              next_rdata[CH_INV_BIT] = ch_inv[i];
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= BYTE_ZERO;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= BYTE_ZERO;
  end

  property p_invert;
    @(posedge clk) disable iff (!nrst)
      ch_en[0] |=> pwm_pin[0] == ($past(level[0]) ^ $past(ch_inv[0]));
  endproperty
  a_invert: assert property (p_invert)
    else $error("channel 0 pin polarity wrong");

  property p_duty_write;
    @(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == {CH_GROUP_OFS, OFS_DUTY_HIGH}
      |=> duty_high[0] == $past(reg_wdata);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("duty high write not stored");

  property p_shared_period;
    @(posedge clk) disable iff (!nrst)
      period_start |=> duty_buf[1] == {$past(duty_high[1]),
                                       $past(duty_low[1])};
  endproperty
  a_shared_period: assert property (p_shared_period)
    else $error("second channel missed the shared period");

  property p_post_free;
    @(posedge clk) disable iff (!nrst)
      tick && phase == PHASE_LAST && count == period && !tb_load &&
      post_cnt != post_sel |=> count == '0 && !postscale_tick;
  endproperty
  a_post_free: assert property (p_post_free)
    else $error("period end blocked or early postscale tick");

  property p_tick_single;
    @(posedge clk) disable iff (!nrst)
      postscale_tick |=> !postscale_tick;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("postscale tick longer than one cycle");

  property p_flag_set_wins;
    @(posedge clk) disable iff (!nrst)
      post_hit |=> post_flag;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("postscale flag lost its set");

  property p_period_write;
    @(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == ADDR_PERIOD |=> period == $past(reg_wdata);
  endproperty
  a_period_write: assert property (p_period_write)
    else $error("period write not stored");

  property p_low_write;
    @(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == {CH_GROUP_OFS, OFS_DUTY_LOW}
      |=> duty_low[0] == $past(reg_wdata[DUTY_LOW_MSB:DUTY_LOW_LSB]);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("duty low write not stored");

  property p_read_idle;
    @(posedge clk) disable iff (!nrst)
      !reg_rd |=> reg_rdata == BYTE_ZERO;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero outside read cycle");
endmodule

/* tb/pwm_load_model.sv */
// Load on one modulator pin, measuring high time and period
`timescale 1ns/1ns
module pwm_load_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Pin, taken as a driven output
  input  wire logic pin,
  // Measurements in clocks
  output int        hi_len,
  output int        per_len,
  output int        n_rise
);
  int   since_rise;
  logic last;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      last       <= 1'b0;
      since_rise <= 0;
      hi_len     <= 0;
      per_len    <= 0;
      n_rise     <= 0;
    end
    else
    begin
      last       <= pin;
      since_rise <= since_rise + 1;
      if (pin && !last)
      begin
        per_len    <= since_rise;
        since_rise <= 1;
        n_rise     <= n_rise + 1;
      end
      if (!pin && last)
        hi_len <= since_rise;
    end
  end
endmodule

/* tb/timer_based_pwm_10bit_test.sv */
// Self-checking bench for the timer based 10-bit modulator
`timescale 1ns/1ns
`define CHECK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module timer_based_pwm_10bit_test
  import pwm_pkg::*;
;
  logic              clk       = 1'b0;
  logic              nrst      = 1'b0;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_CH-1:0] pwm_pin;
  logic              postscale_tick;
  int                hi_len [2];
  int                per_len [2];
  int                n_rise [2];
  int                n_errors    = 0;
  int                check_count = 0;
  int                tick_gap    = 0;
  int                tick_since  = 0;
  int                n_tick      = 0;

  always #50 clk = ~clk;

  // Clocks between postscaled events
  always @(posedge clk)
  begin
    tick_since <= tick_since + 1;
    if (postscale_tick)
    begin
      tick_gap   <= tick_since;
      tick_since <= 1;
      n_tick     <= n_tick + 1;
    end
  end

  timer_based_pwm_10bit dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pwm_pin(pwm_pin),
    .postscale_tick(postscale_tick));

  pwm_load_model load0 (.clk(clk), .nrst(nrst), .pin(pwm_pin[0]),
    .hi_len(hi_len[0]), .per_len(per_len[0]), .n_rise(n_rise[0]));
  pwm_load_model load1 (.clk(clk), .nrst(nrst), .pin(pwm_pin[1]),
    .hi_len(hi_len[1]), .per_len(per_len[1]), .n_rise(n_rise[1]));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [7:0] exp,
                           input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    `CHECK(what, exp, reg_rdata)
  endtask

  function automatic logic [3:0] ch_addr(input int ch, input logic [1:0] o);
    return {CH_GROUP_OFS + 2'(ch), o};
  endfunction

  function automatic int ps_of(input int sel);
    return 1 << (2 * sel);
  endfunction

  // Expected high clocks per period, before any inversion
  function automatic int exp_high(input int p, input int d, input int sel);
    if (d >= 4 * (p + 1))
      return 4 * (p + 1) * ps_of(sel);
    return d * ps_of(sel);
  endfunction

  task automatic run_case(input int sel, input int p, input int post,
                          input int d0, input int d1, input bit inv0);
    int per;
    int hi [2];
    int d [2];
    int rises [2];
    int t0;
    d[0] = d0;
    d[1] = d1;
    per  = 4 * (p + 1) * ps_of(sel);
    reg_write(ADDR_TIMER, 8'h00);
    // Restart the timebase so a smaller period is not overrun
    reg_write(ADDR_TIMEBASE, 8'h00);
    reg_write(ADDR_PERIOD, 8'(p));
    for (int ch = 0; ch < 2; ch++)
    begin
      hi[ch] = exp_high(p, d[ch], sel);
      reg_write(ch_addr(ch, OFS_DUTY_HIGH), 8'(d[ch] >> 2));
      reg_write(ch_addr(ch, OFS_DUTY_LOW), 8'((d[ch] & 3) << 6));
      reg_write(ch_addr(ch, OFS_CTRL), (ch == 0 && inv0) ? 8'h90 : 8'h80);
    end
    if (inv0)
      hi[0] = per - hi[0];
    reg_write(ADDR_TIMER, 8'(128 + post * 4 + sel));
    t0 = n_tick;
    repeat (3 * per + 4) @(posedge clk);
    rises = n_rise;
    repeat (per + 2) @(posedge clk);
    #1;
    for (int ch = 0; ch < 2; ch++)
    begin
      if (hi[ch] == 0 || hi[ch] == per)
      begin
        `CHECK("rise count", rises[ch], n_rise[ch])
        `CHECK("steady pin", (hi[ch] != 0), pwm_pin[ch])
      end
      else
      begin
        `CHECK("high time", hi[ch], hi_len[ch])
        `CHECK("period", per, per_len[ch])
      end
    end
    if (n_tick - t0 >= 2)
      `CHECK("postscale gap", (post + 1) * per, tick_gap)
    $display("case done: prescale %0d period %0d", ps_of(sel), p);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial
  begin
    int sel;
    int p;
    void'($urandom(32'had94));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    #1;
    `CHECK("pins after reset", 2'b00, pwm_pin)
    for (int a = 0; a < 16; a++)
      reg_check(4'(a), (a == 0) ? PERIOD_RST : BYTE_ZERO, "reset");
    $display("test done: reset values");
    reg_write(ch_addr(0, OFS_DUTY_HIGH), 8'ha5);
    reg_write(ch_addr(0, OFS_DUTY_LOW), 8'hff);
    reg_write(4'h7, 8'h5a);
    reg_write(ADDR_PERIOD, 8'h3c);
    reg_check(ch_addr(0, OFS_DUTY_HIGH), 8'ha5, "duty high");
    reg_check(ch_addr(0, OFS_DUTY_LOW), 8'hc0, "duty low");
    reg_check(4'h7, 8'h00, "unmapped");
    reg_check(ADDR_PERIOD, 8'h3c, "period reg");
    $display("test done: register access");
    run_case(0, 9, 0, 13, 39, 0);
    reg_check(ADDR_STATUS, 8'h01, "postscale flag");
    run_case(1, 4, 5, 20, 0, 0);
    reg_check(ADDR_TIMER, 8'h95, "timer control");
    reg_check(ch_addr(0, OFS_CTRL), 8'ha0, "control 0");
    reg_check(ch_addr(1, OFS_CTRL), 8'h80, "control 1");
    run_case(2, 2, 0, 5, 11, 1);
    run_case(3, 1, 15, 3, 8, 0);
    for (int i = 0; i < 4; i++)
    begin
      sel = $urandom_range(0, 3);
      p   = $urandom_range(0, (sel == 3) ? 3 : 7);
      run_case(sel, p, $urandom_range(0, 15),
               $urandom_range(0, 4 * (p + 1) + 1),
               $urandom_range(0, 4 * (p + 1) + 1),
               1'($urandom_range(0, 1)));
    end
    complete_run();
  end
endmodule
